/* src/sram_burst_port.sv */
// Purpose: Device side of a pipelined four-word burst SRAM with a write log
// Assumes: All pins synchronous to aclk; aresetn stands in for power-up
// Notes:   Register window over AXI4-Lite; clock gate freezes only the memory side
//
// Functional notes
// - Read/write ignored while bursting on advance
// - Burst direction fixed at load, kept throughout
// - Sampled load ends any burst in progress
// - Burst steps two low bits, linear/interleaved
// - First word at loaded address, then sequence
// - Write starts on load with read/write low
// - Strobes lead their data by two cycles
// - Gated edge leaves all memory state unchanged
// - Data bus released from first edge on
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Write log FIFO
// ----------------------------------------
module log_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wptr_reg;
	logic [PW-1:0]    rptr_reg;
	logic [PW:0]      count_reg;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// Full and empty straight from the occupancy count
	assign in_ready  = (count_reg != (PW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = store[rptr_reg];

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end else begin
			if (push)
				wptr_reg <= (wptr_reg == PW'(DEPTH - 1)) ? '0 : wptr_reg + PW'(1);
			if (pop)
				rptr_reg <= (rptr_reg == PW'(DEPTH - 1)) ? '0 : rptr_reg + PW'(1);
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Storage has no reset
	always_ff @(posedge aclk) begin
		if (push)
			store[wptr_reg] <= in_data;
	end
endmodule

// ----------------------------------------
// Burst SRAM port
// ----------------------------------------
module sram_burst_port #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 36,
	parameter int LANES  = 4
) (
	input  wire logic                             aclk,
	input  wire logic                             aresetn,
	// Memory side pins
	input  wire logic [ADDR_W-1:0]                addr,
	input  wire logic                             read_not_write,
	input  wire logic                             advance_or_load,
	input  wire logic [LANES-1:0]                 byte_lane_write_strobes_n,
	input  wire logic                             clock_gate_low_active,
	input  wire logic                             chip_select_low_a,
	input  wire logic                             chip_select_low_b,
	input  wire logic                             chip_select_pair,
	input  wire logic                             burst_order_select,
	input  wire logic [DATA_W-1:0]                dq_in,
	output logic      [DATA_W-1:0]                dq_out,
	output logic                                  dq_oe,
	output logic                                  write_log_ready,
	// AXI4-Lite slave
	input  wire logic [sram_port_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                             s_axi_awvalid,
	output logic                                  s_axi_awready,
	input  wire logic [31:0]                      s_axi_wdata,
	input  wire logic [3:0]                       s_axi_wstrb,
	input  wire logic                             s_axi_wvalid,
	output logic                                  s_axi_wready,
	output logic      [1:0]                       s_axi_bresp,
	output logic                                  s_axi_bvalid,
	input  wire logic                             s_axi_bready,
	input  wire logic [sram_port_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                             s_axi_arvalid,
	output logic                                  s_axi_arready,
	output logic      [31:0]                      s_axi_rdata,
	output logic      [1:0]                       s_axi_rresp,
	output logic                                  s_axi_rvalid,
	input  wire logic                             s_axi_rready
);
	import sram_port_pkg::*;

	localparam int LANE_W = DATA_W / LANES;

	// Next low address bits of a burst step
	function automatic logic [1:0] burst_low(input logic [1:0] base,
	                                         input logic [1:0] step,
	                                         input logic       interleave);
		burst_low = interleave ? (base ^ step) : (base + step);
	endfunction

	// Register window decode, shared by write and read paths
	function automatic reg_sel_e reg_sel(input logic [AXI_AW-1:0] a);
		if (a[1:0] != 2'b00)
			reg_sel = SEL_NONE;
		else if (a == OFS_CTRL)
			reg_sel = SEL_CTRL;
		else if (a == OFS_STATUS)
			reg_sel = SEL_STATUS;
		else if (a == OFS_LOG)
			reg_sel = SEL_LOG;
		else if (a == OFS_WCOUNT)
			reg_sel = SEL_WCOUNT;
		else
			reg_sel = SEL_NONE;
	endfunction

	logic [DATA_W-1:0] mem [2**ADDR_W];

	logic              burst_active_reg;
	logic              burst_write_reg;
	logic [1:0]        burst_cnt_reg;
	logic [ADDR_W-1:0] base_reg;
	logic              s1_valid_reg;
	logic              s1_write_reg;
	logic [ADDR_W-1:0] s1_addr_reg;
	logic [LANES-1:0]  s1_strb_reg;
	logic              s2_valid_reg;
	logic              s2_write_reg;
	logic [ADDR_W-1:0] s2_addr_reg;
	logic [LANES-1:0]  s2_strb_reg;
	logic [DATA_W-1:0] dq_out_reg;
	logic              dq_oe_reg;
	logic [31:0]       ctrl_reg;
	logic [31:0]       wcount_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       rdata_reg;

	// ----------------------------------------
	// Pin decode
	// ----------------------------------------
	wire       en        = !clock_gate_low_active;
	wire       selected  = !chip_select_low_a && !chip_select_low_b && chip_select_pair;
	wire       load      = !advance_or_load;
	wire       load_sel  = load && selected;
	wire       advance   = advance_or_load && burst_active_reg;
	wire       order_int = ctrl_reg[CTRL_ORDER_OVR_BIT] ? ctrl_reg[CTRL_ORDER_VAL_BIT]
	                                                    : burst_order_select;
	wire [1:0] cnt_step  = burst_cnt_reg + STEP_ONE;
	wire [1:0] next_low  = burst_low(base_reg[1:0], cnt_step, order_int);
	wire       commit_wr = en && s2_valid_reg && s2_write_reg;

	// ----------------------------------------
	// Burst tracking
	// ----------------------------------------
	// Deselected load still ends a burst; pending transfers drain anyway
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_active_reg <= 1'b0;
			burst_write_reg  <= 1'b0;
			burst_cnt_reg    <= STEP_ZERO;
			base_reg         <= '0;
		end else if (en) begin
			if (load) begin
				burst_active_reg <= selected;
				burst_cnt_reg    <= STEP_ZERO;
				if (selected) begin
					base_reg        <= addr;
					burst_write_reg <= !read_not_write;
				end
			end else if (burst_active_reg) begin
				burst_cnt_reg <= cnt_step;
			end
		end
	end

	// ----------------------------------------
	// Two-stage access pipeline
	// ----------------------------------------
	// Stage one holds the address of this cycle's access
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_valid_reg <= 1'b0;
			s1_write_reg <= 1'b0;
			s1_addr_reg  <= '0;
			s1_strb_reg  <= '1;
		end else if (en) begin
			s1_valid_reg <= load_sel || (!load && advance);
			s1_write_reg <= load ? !read_not_write : burst_write_reg;
			s1_addr_reg  <= load ? addr
			                     : {base_reg[ADDR_W-1:2], next_low};
			s1_strb_reg  <= byte_lane_write_strobes_n;
		end
	end

	// Stage two is the data cycle; strobes ride along two edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s2_valid_reg <= 1'b0;
			s2_write_reg <= 1'b0;
			s2_addr_reg  <= '0;
			s2_strb_reg  <= '1;
		end else if (en) begin
			s2_valid_reg <= s1_valid_reg;
			s2_write_reg <= s1_write_reg;
			s2_addr_reg  <= s1_addr_reg;
			s2_strb_reg  <= s1_strb_reg;
		end
	end

	// Read data launched one edge early so it stands in the data cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dq_oe_reg  <= 1'b0;
			dq_out_reg <= '0;
		end else if (en) begin
			dq_oe_reg <= s1_valid_reg && !s1_write_reg;
			if (s1_valid_reg && !s1_write_reg)
				dq_out_reg <= mem[s1_addr_reg];
		end
	end

	assign dq_out = dq_out_reg;
	assign dq_oe  = dq_oe_reg;

	// ----------------------------------------
	// Byte-lane write merge
	// ----------------------------------------
	// Masked lanes keep old contents; costs a read port on the array
	logic [DATA_W-1:0] merged;
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign merged[g*LANE_W +: LANE_W] = s2_strb_reg[g]
			                                  ? mem[s2_addr_reg][g*LANE_W +: LANE_W]
			                                  : dq_in[g*LANE_W +: LANE_W];
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (commit_wr)
			mem[s2_addr_reg] <= merged;
	end

	// ----------------------------------------
	// Write log and counter
	// ----------------------------------------
	wire                 log_out_valid;
	wire [LOG_WIDTH-1:0] log_out_data;
	wire                 log_pop;

	// Log drops words while full; the ready pin lets the controller know
	log_fifo #(
		.WIDTH (LOG_WIDTH),
		.DEPTH (LOG_DEPTH)
	) u_log (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (dq_in[LOG_WIDTH-1:0]),
		.in_valid  (commit_wr),
		.in_ready  (write_log_ready),
		.out_data  (log_out_data),
		.out_valid (log_out_valid),
		.out_ready (log_pop)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			wcount_reg <= '0;
		else if (commit_wr)
			wcount_reg <= wcount_reg + 32'h0000_0001;
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// Address and data are taken together, one write outstanding
	wire       wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	wire       rd_take = s_axi_arvalid && !rvalid_reg;
	reg_sel_e  wsel;
	reg_sel_e  rsel;
	assign wsel          = reg_sel(s_axi_awaddr);
	assign rsel          = reg_sel(s_axi_araddr);
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_arready = !rvalid_reg;
	assign log_pop       = rd_take && (rsel == SEL_LOG) && log_out_valid;

	wire [31:0] status_word = {26'h0,
	                           !write_log_ready,
	                           !log_out_valid,
	                           burst_cnt_reg,
	                           burst_write_reg,
	                           burst_active_reg};

	// Control register and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg   <= CTRL_RESET;
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else begin
			if (wr_take) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
				if (wsel == SEL_CTRL && s_axi_wstrb[0])
					ctrl_reg[7:0] <= s_axi_wdata[7:0] & 8'h03;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read data mux; a log read pops the head, empty reads as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= RESP_OKAY;
			rdata_reg  <= '0;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			case (rsel)
				SEL_CTRL:   rdata_reg <= ctrl_reg;
				SEL_STATUS: rdata_reg <= status_word;
				SEL_LOG:    rdata_reg <= log_out_valid ? log_out_data : 32'h0;
				SEL_WCOUNT: rdata_reg <= wcount_reg;
				default:    rdata_reg <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence sq_load_write;
		en && load_sel && !read_not_write;
	endsequence

	sequence sq_load_read;
		en && load_sel && read_not_write;
	endsequence

	AST_BURST_IGNORES_RW: assert property (en && advance_or_load && burst_active_reg
		|=> s1_write_reg == $past(burst_write_reg))
		else $error("burst access changed direction");

	AST_DIR_FIXED: assert property (en && load_sel
		|=> burst_write_reg == !$past(read_not_write))
		else $error("burst direction not taken at load");

	AST_LOAD_ENDS_BURST: assert property (en && load
		|=> burst_cnt_reg == STEP_ZERO && burst_active_reg == $past(selected))
		else $error("load did not restart burst");

	AST_STEP_LOW_BITS: assert property (en && advance_or_load && burst_active_reg
		|=> s1_addr_reg == {$past(base_reg[ADDR_W-1:2]), $past(next_low)}
		    && s1_addr_reg[ADDR_W-1:2] == base_reg[ADDR_W-1:2])
		else $error("burst stepped outside low bits");

	AST_FIRST_WORD: assert property (en && load_sel
		|=> s1_valid_reg && s1_addr_reg == $past(addr))
		else $error("first word not at loaded address");

	AST_WRITE_START: assert property (sq_load_write
		|=> s1_valid_reg && s1_write_reg)
		else $error("write cycle not started");

	AST_STROBE_LEAD: assert property (sq_load_write ##1 en
		|=> s2_write_reg && s2_strb_reg == $past(byte_lane_write_strobes_n, 2))
		else $error("strobes not paired two cycles ahead");

	AST_GATE_FREEZE: assert property (!en
		|=> $stable(s1_addr_reg) && $stable(s2_valid_reg) && $stable(burst_cnt_reg)
		    && $stable(dq_oe_reg))
		else $error("gated edge changed state");

	AST_BUS_IDLE: assert property (en && !s1_valid_reg |=> !dq_oe)
		else $error("bus driven without a read");

	AST_READ_LAG: assert property (sq_load_read ##1 en |=> dq_oe && !s2_write_reg)
		else $error("read data not on bus two cycles after load");

endmodule

`default_nettype wire

/* src/sram_port_pkg.sv */
// Purpose: Shared constants for the pipelined burst SRAM port
// Assumes: 32-bit AXI4-Lite register window, one aligned word per register
// Notes:   Offsets, field positions, reset values and pipeline figures live here
package sram_port_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int         AXI_AW     = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_LOG    = 8'h08;
	localparam logic [7:0] OFS_WCOUNT = 8'h0c;

	// Control fields
	localparam int          CTRL_ORDER_OVR_BIT = 0;
	localparam int          CTRL_ORDER_VAL_BIT = 1;
	localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;

	// Status fields
	localparam int ST_ACTIVE_BIT    = 0;
	localparam int ST_WRITE_BIT     = 1;
	localparam int ST_CNT_LSB       = 2;
	localparam int ST_LOG_EMPTY_BIT = 4;
	localparam int ST_LOG_FULL_BIT  = 5;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------
	// Memory port figures
	// ----------------------------------------
	localparam int         DATA_LAG   = 2;     // Enabled edges from load to data
	localparam int         LOG_DEPTH  = 8;     // Write log entries
	localparam int         LOG_WIDTH  = 32;
	localparam logic [1:0] STEP_ONE   = 2'b01;
	localparam logic [1:0] STEP_ZERO  = 2'b00;

	// Register selector
	typedef enum logic [2:0] {
		SEL_CTRL   = 3'b000,
		SEL_STATUS = 3'b001,
		SEL_LOG    = 3'b010,
		SEL_WCOUNT = 3'b011,
		SEL_NONE   = 3'b100
	} reg_sel_e;

endpackage

/* testbench/mem_ctl_model.sv */
// Purpose: Memory controller model for the burst SRAM pins
// Assumes: op is called once per cycle by the bench
// Notes:   Write data trails its load by two enabled cycles
`timescale 1ns/1ps
`default_nettype none
module mem_ctl_model (
	input  wire logic        aclk,
	output logic      [17:0] addr,
	output logic             read_not_write,
	output logic             advance_or_load,
	output logic      [3:0]  byte_lane_write_strobes_n,
	output logic             clock_gate_low_active,
	output logic             chip_select_low_a,
	output logic             chip_select_low_b,
	output logic             chip_select_pair,
	output logic             burst_order_select,
	output logic      [35:0] dq_in
);
	logic        burst_on;
	logic        burst_wr;
	logic [1:0]  wq_v;
	logic [35:0] wq_d [2];

	// Deselected and idle from time zero
	initial begin
		{addr, read_not_write, advance_or_load, burst_order_select, dq_in} = '0;
		{chip_select_low_a, chip_select_low_b, chip_select_pair} = 3'b110;
		{clock_gate_low_active, burst_on, burst_wr, wq_v} = '0;
		byte_lane_write_strobes_n = 4'hf;
	end

	// Burst order pin is static; changed only between bursts
	task automatic set_order(input logic o);
		burst_order_select <= o;
	endtask

	// One bus cycle; gated cycles do not move the data pipeline
	task automatic op(input logic adv, input logic rnw, input logic [17:0] a,
	                  input logic [3:0] sn, input logic sel, input logic gate,
	                  input logic [35:0] wd);
		@(posedge aclk);
		advance_or_load <= adv;
		read_not_write <= rnw;
		addr <= a;
		byte_lane_write_strobes_n <= sn;
		chip_select_low_a <= !sel;
		chip_select_low_b <= !sel;
		chip_select_pair <= sel;
		clock_gate_low_active <= gate;
		// Idle data lines toggle so a stale word never looks valid
		dq_in <= (!gate && wq_v[1]) ? wq_d[1] : ~dq_in;
		if (!gate) begin
			if (!adv) begin
				burst_on = sel;
				burst_wr = sel && !rnw;
			end
			wq_v = {wq_v[0], burst_on && burst_wr};
			wq_d[1] = wq_d[0];
			wq_d[0] = wd;
		end
	endtask
endmodule
`default_nettype wire

/* testbench/pipelined_burst_sram_port_test.sv */
// Purpose: Self-checking bench for the burst SRAM port and register window
// Assumes: Controller model drives memory pins, bench drives AXI4-Lite
// Notes:   Shadow of addresses 0..15 gives expected read data
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_port_test;
	import sram_port_pkg::*;

	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	wire  [17:0]       addr;
	wire               read_not_write, advance_or_load, clock_gate_low_active;
	wire               chip_select_low_a, chip_select_low_b, chip_select_pair;
	wire               burst_order_select, dq_oe, write_log_ready;
	wire  [3:0]        byte_lane_write_strobes_n;
	wire  [35:0]       dq_in, dq_out;
	logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]       s_axi_wdata = '0;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic              s_axi_arvalid = 0, s_axi_rready = 0;
	wire               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]        s_axi_bresp, s_axi_rresp;
	wire  [31:0]       s_axi_rdata;
	int                n_mismatch = 0, cmp_count = 0;
	logic [35:0]       shadow [16];
	logic [31:0]       rd;
	logic [1:0]        rs;

	mem_ctl_model ctl (.aclk, .addr, .read_not_write, .advance_or_load, .byte_lane_write_strobes_n,
		.clock_gate_low_active, .chip_select_low_a, .chip_select_low_b, .chip_select_pair,
		.burst_order_select, .dq_in);
	sram_burst_port uut (.aclk, .aresetn, .addr, .read_not_write, .advance_or_load,
		.byte_lane_write_strobes_n, .clock_gate_low_active, .chip_select_low_a,
		.chip_select_low_b, .chip_select_pair, .burst_order_select, .dq_in, .dq_out, .dq_oe,
		.write_log_ready, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	// --------------------------------
	// Helpers
	// --------------------------------
	task automatic chk(input logic [36:0] got, input logic [36:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk({35'h0, got}, {35'h0, exp});
	endtask
	function automatic logic [35:0] pat(input logic [7:0] k);
		return {k[3:0], 8'ha5, k, 8'h3c, k};
	endfunction
	task automatic idle(input int n);
		repeat (n) ctl.op(1'b0, 1'b1, 18'h0, 4'hf, 1'b0, 1'b0, 36'h0);
	endtask
	// Gated cycle carries a live write load, so a leak would corrupt word 15
	task automatic gate();
		ctl.op(1'b0, 1'b0, 18'hf, 4'h0, 1'b1, 1'b1, 36'h0);
	endtask
	task automatic see(input logic oe, input logic [3:0] a);
		#1;
		chk({dq_oe, oe ? dq_out : 36'h0}, {oe, oe ? shadow[a] : 36'h0});
	endtask
	task automatic wr1(input logic [3:0] a, input logic [3:0] sn, input logic [7:0] k);
		ctl.op(1'b0, 1'b0, {14'h0, a}, sn, 1'b1, 1'b0, pat(k));
		for (int g = 0; g < 4; g++)
			if (!sn[g]) shadow[a][9*g +: 9] = 9'(pat(k) >> (9 * g));
	endtask
	task automatic rd1(input logic [3:0] a);
		ctl.op(1'b0, 1'b1, {14'h0, a}, 4'hf, 1'b1, 1'b0, 36'h0);
	endtask
	task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
		int t;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (t = 0; t < 50 && !s_axi_bvalid; t++) begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (t == 50) n_mismatch++;
	endtask
	task automatic axi_rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (t = 0; t < 50 && !s_axi_rvalid; t++) begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (t == 50) n_mismatch++;
	endtask
	// Four words, then two deselects to flush the data pipe
	task automatic burst(input logic wr, input logic [3:0] a, input logic pin, input logic il,
	                     input logic [7:0] b);
		logic [3:0] ea [4];
		ctl.set_order(pin);
		for (int k = 0; k < 6; k++) begin
			if (k < 4) ea[k] = {a[3:2], il ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0]};
			if (k < 4 && wr) shadow[ea[k]] = pat(b + k[7:0]);
			if (k == 0) ctl.op(1'b0, !wr, {14'h0, a}, 4'h0, 1'b1, 1'b0, pat(b));
			else if (k < 4) ctl.op(1'b1, wr, 18'h3ffff, 4'h0, 1'b1, 1'b0, pat(b + k[7:0]));
			else idle(1);
			if (!wr && k > 1) see(1'b1, ea[k-2]);
		end
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_regs();
		chk({36'h0, dq_oe}, 37'h0);
		axi_rd(OFS_CTRL, rd, rs);
		chk({5'h0, rd}, {5'h0, CTRL_RESET});
		chk_resp(rs, RESP_OKAY);
		axi_wr(OFS_STATUS, 32'hffff_ffff, rs);
		chk_resp(rs, RESP_OKAY);
		axi_rd(OFS_STATUS, rd, rs);
		chk({5'h0, rd}, 37'h10);
		axi_rd(8'h10, rd, rs);
		chk({3'h0, rs, rd}, {3'h0, RESP_SLVERR, 32'h0});
		axi_wr(8'h14, 32'h1, rs);
		chk_resp(rs, RESP_SLVERR);
		axi_wr(OFS_CTRL, 32'h3, rs);
		axi_rd(OFS_CTRL, rd, rs);
		chk({5'h0, rd}, 37'h3);
		$display("registers done");
	endtask
	// Nine back-to-back writes overflow the eight-entry log
	task automatic t_log();
		axi_wr(OFS_CTRL, 32'h0, rs);
		for (int k = 0; k < 9; k++) wr1(k[3:0], 4'h0, k[7:0]);
		idle(3);
		chk({36'h0, write_log_ready}, 37'h0);
		axi_rd(OFS_WCOUNT, rd, rs);
		chk({5'h0, rd}, 37'h9);
		for (int k = 0; k < 8; k++) begin
			axi_rd(OFS_LOG, rd, rs);
			chk({5'h0, rd}, {5'h0, 8'ha5, k[7:0], 8'h3c, k[7:0]});
		end
		axi_rd(OFS_STATUS, rd, rs);
		chk({35'h0, rd[5:4]}, 37'h1);
		$display("write log done");
	endtask
	task automatic t_burst();
		burst(1'b1, 4'h2, 1'b0, 1'b0, 8'h20);
		burst(1'b0, 4'h1, 1'b1, 1'b1, 8'h0);
		axi_wr(OFS_CTRL, 32'h3, rs);
		burst(1'b0, 4'h6, 1'b0, 1'b1, 8'h0);
		axi_wr(OFS_CTRL, 32'h0, rs);
		burst(1'b0, 4'h5, 1'b0, 1'b0, 8'h0);
		$display("bursts done");
	endtask
	task automatic t_lanes();
		wr1(4'h3, 4'b1010, 8'h77);
		idle(2);
		rd1(4'h3);
		idle(2);
		see(1'b1, 4'h3);
		idle(2);
		$display("byte lanes done");
	endtask
	// Gated edges between load and data must not count
	task automatic t_gate();
		wr1(4'hf, 4'h0, 8'h55);
		wr1(4'h9, 4'h0, 8'h40);
		gate();
		idle(1);
		gate();
		idle(3);
		rd1(4'h9);
		gate();
		idle(1);
		see(1'b0, 4'h0);
		gate();
		see(1'b1, 4'h9);
		idle(1);
		see(1'b1, 4'h9);
		idle(1);
		see(1'b0, 4'h0);
		rd1(4'hf);
		idle(2);
		see(1'b1, 4'hf);
		$display("clock gate done");
	endtask
	// Deselected load ends the burst; a later advance starts nothing
	task automatic t_desel();
		rd1(4'h5);
		ctl.op(1'b0, 1'b1, 18'h5, 4'hf, 1'b0, 1'b0, 36'h0);
		ctl.op(1'b1, 1'b1, 18'h3ffff, 4'hf, 1'b1, 1'b0, 36'h0);
		see(1'b1, 4'h5);
		idle(1);
		see(1'b0, 4'h0);
		idle(1);
		see(1'b0, 4'h0);
		$display("deselect done");
	endtask

	// --------------------------------
	// Run control
	// --------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Clock
	initial begin
		forever #2 aclk = ~aclk;
	end

	// Watchdog, well past the 130 or so cycles the tests need
	initial begin
		#40000;
		n_mismatch++;
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		idle(2);
		t_regs();
		t_log();
		t_burst();
		t_lanes();
		t_gate();
		t_desel();
		stop_test();
	end
endmodule
`default_nettype wire
